// ### bench/uecs_usb_host.sv
// Host-side model that issues USB bus events as one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module uecs_usb_host
   import uecs_pkg::*;
(
   input  wire logic          clk,
   output var uecs_usb_event_s usbEv
);
   initial usbEv = '0;
   // Every field drops to zero after a pulse, so no stale frame lingers
   task go(input uecs_usb_event_s e);
      @(posedge clk);
      usbEv <= e;
      @(posedge clk);
      usbEv <= '0;
   endtask
   task sof(input logic [10:0] f, input logic c);
      go({2'b01, c, f, 7'h00});
   endtask
   task breset();
      go({1'b1, 20'h0});
   endtask
   task setup(input logic [2:0] ep, input logic dirIn);
      go({14'h0, 1'b1, dirIn, 2'b00, ep});
   endtask
   task hbyte(input logic [2:0] ep);
      go({16'h0, 2'b10, ep});
   endtask
   task bdone(input logic [2:0] ep);
      go({16'h0, 2'b01, ep});
   endtask
endmodule
`default_nettype wire

// ### bench/usb_device_endpoint_config_status_test.sv
// Self-checking bench for the endpoint configuration/status block
`timescale 1ns/10ps
`default_nettype none
module usb_device_endpoint_config_status_test;
   import uecs_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, seed = 32'h047A4EF9;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [6:0]  epError = '0, endpointIrq, endpointEnable;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   uecs_sw_fifo_s   swFifo = '0;
   uecs_usb_event_s usbEv;
   int miscompares = 0, checks = 0, cyc = 0;
   uecs_top uecs_top_inst (.*);
   uecs_usb_host uecs_usb_host_inst (.clk(clk), .usbEv(usbEv));
   initial forever #2 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [11:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      {d, rr} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   task sw(input logic [2:0] ep);
      @(posedge clk);
      swFifo <= {1'b1, ep};
      @(posedge clk);
      swFifo <= '0;
   endtask
   task report_and_stop();
      if (miscompares == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Ceiling far above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      logic [31:0] cfg [7];
      logic [10:0] f;
      logic        c;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      rd(OFS_EP_STATUS + 12'h018); chk(d, 32'h100);
      rd(12'hFF0); chk({30'h0, rr}, {30'h0, RESP_SLVERR});
      {f, c} = 12'(rnd());
      uecs_usb_host_inst.sof(f, c);
      rd(OFS_FRAME_NUMBER); chk(d, {16'h0, c, 1'b0, f, 3'h0});
      wr(OFS_EP_ENABLE, 32'h7F);
      for (int i = 0; i < NUM_EP; i++) begin
         cfg[i] = rnd() & 32'h1B3C;
         wr(OFS_EP_CONFIG + 12'(4 * i), cfg[i]);
         rd(OFS_EP_CONFIG + 12'(4 * i)); chk(d, cfg[i]);
      end
      uecs_usb_host_inst.breset();
      rd(OFS_FRAME_NUMBER); chk(d, 32'h0);
      for (int i = 0; i < NUM_EP; i++) begin
         rd(OFS_EP_CONFIG + 12'(4 * i));
         chk(d, i == 0 ? cfg[0] & 32'hFC : 32'h0);
      end
      wr(OFS_EP_CONFIG + 12'h004, 32'h116C);
      rd(OFS_EP_STATUS + 12'h004); chk(d[STA_CFG_OK], 1'b1);
      wr(OFS_EP_CONFIG + 12'h008, 32'h101C);
      rd(OFS_EP_STATUS + 12'h008); chk(d[STA_CFG_OK], 1'b0);
      wr(OFS_EP_CONFIG + 12'h008, 32'h100C);
      uecs_usb_host_inst.hbyte(3'h2);
      rd(OFS_EP_STATUS + 12'h008); chk(d[STA_CFG_OK], 1'b1);
      chk(d[30:20], 11'h1);
      wr(OFS_EP_CONFIG, 32'h4);
      rd(OFS_EP_STATUS); chk(d[STA_CFG_OK], 1'b1);
      uecs_usb_host_inst.setup(3'h0, 1'b1);
      rd(OFS_EP_STATUS); chk(d[STA_CTRL_DIR], 1'b1);
      repeat (3) sw(3'h1);
      uecs_usb_host_inst.hbyte(3'h1);
      rd(OFS_EP_STATUS + 12'h004); chk(d[30:20], 11'h2);
      wr(OFS_EP_CONTROL + 12'h004, 32'h1);
      rd(OFS_EP_STATUS + 12'h004); chk(endpointIrq[1], 1'b1);
      wr(OFS_EP_CONTROL + 12'h004, 32'h5);
      rd(OFS_EP_STATUS + 12'h004); chk(d[13:12], 2'h1);
      chk(endpointIrq[1], 1'b0);
      chk(d[STA_RW_OK], 1'b1);
      epError <= 7'h02;
      rd(OFS_EP_STATUS + 12'h004); chk(d[STA_RW_OK], 1'b0);
      epError <= '0;
      wr(OFS_EP_CONTROL + 12'h004, 32'h3);
      rd(OFS_EP_STATUS + 12'h004); chk(d[STA_RW_OK], 1'b0);
      uecs_usb_host_inst.bdone(3'h1);
      rd(OFS_EP_STATUS + 12'h004); chk(d[13:8], 6'h00);
      chk(endpointIrq[1], 1'b1);
      wr(OFS_EP_ENABLE, 32'h7D);
      rd(OFS_EP_CONFIG + 12'h004); chk(d, 32'h116C);
      rd(OFS_EP_STATUS + 12'h004); chk(d, 32'h100);
      report_and_stop();
   end
endmodule
`default_nettype wire

// ### verilog/uecs_pkg.sv
// Constants and carrier types of the endpoint configuration/status block
package uecs_pkg;
   localparam int NUM_EP = 7;
   localparam int ADDR_W = 12;

   localparam logic [11:0] OFS_EP_ENABLE    = 12'h01C;
   localparam logic [11:0] OFS_FRAME_NUMBER = 12'h020;
   localparam logic [11:0] OFS_EP_CONFIG    = 12'h100;
   localparam logic [11:0] OFS_EP_STATUS    = 12'h130;
   localparam logic [11:0] OFS_EP_CONTROL   = 12'h1C0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Frame number register
   localparam int FRM_CRC_ERR = 15;
   localparam int FRM_NUM_LSB = 3;
   // Endpoint configuration register
   localparam int CFG_TYPE_LSB = 11;
   localparam int CFG_AUTO_BANK_SWITCH   = 9;
   localparam int CFG_DIR      = 8;
   localparam int CFG_SIZE_LSB = 5;
   localparam int CFG_BANK_LSB = 3;
   localparam int CFG_MEMORY_ALLOCATE    = 2;
   // Endpoint status register
   localparam int STA_BYTES_LSB = 20;
   localparam int STA_CFG_OK    = 18;
   localparam int STA_CTRL_DIR  = 17;
   localparam int STA_RW_OK     = 16;
   localparam int STA_CURR_LSB  = 14;
   localparam int STA_BUSY_LSB  = 12;
   localparam int STA_DATA_TOGGLE_SEQ_LSB = 8;
   // Endpoint control register
   localparam int CTL_BUSY_IE  = 0;
   localparam int CTL_STALL    = 1;
   localparam int CTL_FIFO_CLR = 2;

   localparam logic [1:0]  DATA_TOGGLE_SEQ_RESET        = 2'h1;
   localparam logic [1:0]  BANK_CODE_RESERVED = 2'h3;
   localparam logic [1:0]  EP0_MAX_BANK_CODE  = 2'h0;
   localparam logic [1:0]  EPN_MAX_BANK_CODE  = 2'h2;
   localparam logic [2:0]  EP0_MAX_SIZE_CODE  = 3'h3;
   localparam logic [2:0]  EPN_MAX_SIZE_CODE  = 3'h7;
   localparam logic [15:0] DPRAM_BYTES        = 16'h1000;
   localparam logic [10:0] BANK_UNIT_BYTES    = 11'h008;
   localparam logic [10:0] BYTE_COUNT_MAX     = 11'h7FF;

   typedef enum logic [1:0] {
      EP_CONTROL     = 2'h0,
      EP_ISOCHRONOUS = 2'h1,
      EP_BULK        = 2'h2,
      EP_INTERRUPT   = 2'h3
   } uecs_ep_type_e;

   typedef struct packed {
      logic        busReset;
      logic        sofValid;
      logic        sofCrcError;
      logic [10:0] sofFrame;
      logic        setupValid;
      logic        setupDirIn;
      logic        hostByte;
      logic        bankDone;
      logic [2:0]  ep;
   } uecs_usb_event_s;

   typedef struct packed {
      logic       access;
      logic [2:0] ep;
   } uecs_sw_fifo_s;
endpackage

// ### verilog/uecs_top.sv
// Endpoint configuration and status logic with AXI4-Lite register access
`timescale 1ns/10ps
`default_nettype none

// Contract
// R1: Disabled endpoint goes idle, status resets
// R2: Frame CRC error flag tracks SOF
// R3: Hold last SOF frame number, bus-reset clear
// R4: Endpoint type decode, cleared on bus reset
// R5: Auto bank switch bit, cleared on reset
// R6: Direction bit IN/OUT, cleared on reset
// R7: Bank size code, kept for endpoint zero
// R8: Bank count code, kept for endpoint zero
// R9: Software uses one bank on control
// R10: Allocate bit, kept for endpoint zero
// R11: Config ok evaluated on every allocate; an allocate written while the endpoint is disabled leaves it clear
// R12: Software rewrites bank fields when rejected
// R13: Byte count follows FIFO fill and drain
// R14: Count and bank may lag one cycle
// R15: Setup packet sets control direction
// R16: Read/write allowed from bank state
// R17: Software ignores rw-allowed on control
// R18: Current bank reported for non-control endpoints
// R19: Busy bank count per direction
// R20: Busy bank interrupt when free or full
// R21: Busy count updates two cycles after release
// R22: Data toggle resets to Data1
// R23: Registers replicated per endpoint, stride four
module uecs_top
   import uecs_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   input  wire uecs_usb_event_s   usbEv,
   input  wire uecs_sw_fifo_s     swFifo,
   input  wire logic [NUM_EP-1:0] epError,
   output logic [NUM_EP-1:0]      endpointIrq,
   output logic [NUM_EP-1:0]      endpointEnable
);

   logic [11:0]   wrAddr;
   logic [31:0]   wrData;
   logic [3:0]    wrStrb;
   logic [31:0]   wrMask;
   logic          doWrite;
   logic [3:0]    wCfg;
   logic [3:0]    wCtl;
   logic [3:0]    wSta;
   logic          wMapped;
   logic [3:0]    rCfg;
   logic [3:0]    rCtl;
   logic [3:0]    rSta;
   logic [31:0]   rdWord;
   logic          rdOk;
   logic [10:0]   frameValue;
   logic          frameCrcError;
   logic [15:0]   totalBytes;
   logic [NUM_EP-1:0] irqNext;

   uecs_ep_type_e endpoint_type    [NUM_EP];
   logic          auto_bank_switch    [NUM_EP];
   logic          dirIn     [NUM_EP];
   logic [2:0]    sizeCode  [NUM_EP];
   logic [1:0]    bankCode  [NUM_EP];
   logic          memory_allocate     [NUM_EP];
   logic          config_ok     [NUM_EP];
   logic          control_direction   [NUM_EP];
   logic          rwAllowed [NUM_EP];
   logic [10:0]   byteCount [NUM_EP];
   logic [1:0]    currBank  [NUM_EP];
   logic [1:0]    busyBanks [NUM_EP];
   logic [1:0]    data_toggle_seq     [NUM_EP];
   logic [1:0]    clrPipe   [NUM_EP];
   logic          busyIrqEn [NUM_EP];
   logic          stallReq  [NUM_EP];
   logic [15:0]   usage     [NUM_EP];
   logic [31:0]   cfgWord   [NUM_EP];
   logic [31:0]   staWord   [NUM_EP];
   logic [31:0]   ctlWord   [NUM_EP];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // Valid flag on top, endpoint index below
   function automatic logic [3:0] ep_slot(input logic [11:0] a,
                                          input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      ep_slot = {(a >= base) && (d[1:0] == 2'h0) &&
                 (d[11:2] < 10'(NUM_EP)), d[4:2]};
   endfunction

   // Write channel: address and data are taken independently
   assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wrMask  = {{8{wrStrb[3]}}, {8{wrStrb[2]}},
                     {8{wrStrb[1]}}, {8{wrStrb[0]}}};
   assign wCfg    = ep_slot(wrAddr, OFS_EP_CONFIG);
   assign wCtl    = ep_slot(wrAddr, OFS_EP_CONTROL);
   assign wSta    = ep_slot(wrAddr, OFS_EP_STATUS);
   assign wMapped = wCfg[3] || wCtl[3] || wSta[3] ||
                    wrAddr == OFS_EP_ENABLE || wrAddr == OFS_FRAME_NUMBER;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_awready <= 1'b1;
         wrAddr        <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         wrAddr        <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_wready <= 1'b1;
         wrData       <= 32'h0000_0000;
         wrStrb       <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         wrData       <= s_axi_wdata;
         wrStrb       <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Writes to read-only registers are ignored but still answered OKAY
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel answers one cycle after the address is taken
   assign rCfg = ep_slot(s_axi_araddr, OFS_EP_CONFIG);
   assign rCtl = ep_slot(s_axi_araddr, OFS_EP_CONTROL);
   assign rSta = ep_slot(s_axi_araddr, OFS_EP_STATUS);

   always_comb begin
      rdWord = 32'h0000_0000;
      rdOk   = 1'b1;
      if (rCfg[3]) begin
         rdWord = cfgWord[rCfg[2:0]];
      end else if (rSta[3]) begin
         rdWord = staWord[rSta[2:0]];
      end else if (rCtl[3]) begin
         rdWord = ctlWord[rCtl[2:0]];
      end else if (s_axi_araddr == OFS_EP_ENABLE) begin
         rdWord[NUM_EP-1:0] = endpointEnable;
      end else if (s_axi_araddr == OFS_FRAME_NUMBER) begin
         rdWord[FRM_CRC_ERR]          = frameCrcError;
         rdWord[FRM_NUM_LSB +: 11]    = frameValue;
      end else begin
         rdOk = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdWord;
         s_axi_rresp   <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         endpointEnable <= '0;
      end else if (doWrite && wrAddr == OFS_EP_ENABLE) begin
         endpointEnable <= (endpointEnable & ~wrMask[NUM_EP-1:0]) |
                           (wrData[NUM_EP-1:0] & wrMask[NUM_EP-1:0]);
      end
   end

   // A corrupted SOF still loads the frame number
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         frameValue    <= 11'h000;
         frameCrcError <= 1'b0;
      end else if (usbEv.busReset) begin
         frameValue    <= 11'h000; // R3
         frameCrcError <= 1'b0; // R2
      end else if (usbEv.sofValid) begin
         frameValue    <= usbEv.sofFrame; // R3
         frameCrcError <= usbEv.sofCrcError; // R2
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         endpointIrq <= '0;
      end else begin
         endpointIrq <= irqNext;
      end
   end

   // Memory already claimed by allocated endpoints
   always_comb begin
      totalBytes = 16'h0000;
      for (int j = 0; j < NUM_EP; j++) begin
         if (memory_allocate[j]) begin
            totalBytes = totalBytes + usage[j];
         end
      end
   end

   for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
      localparam logic [2:0] EP_ID = 3'(i);
      localparam logic [1:0] MAX_BANK =
         (i == 0) ? EP0_MAX_BANK_CODE : EPN_MAX_BANK_CODE;
      localparam logic [2:0] MAX_SIZE =
         (i == 0) ? EP0_MAX_SIZE_CODE : EPN_MAX_SIZE_CODE;
      logic [31:0] newCfg;
      logic [15:0] newNeed;
      logic [15:0] others;
      logic [10:0] sizeBytes;
      logic [2:0]  nb;
      logic        fits;
      logic        cfgWr;
      logic        clrWr;
      logic        kill;
      logic        isCtrl;
      logic        hostHit;
      logic        swHit;
      logic        bankHit;
      logic        up;
      logic        dn;
      logic        inc;
      logic        dec;

      assign cfgWr   = doWrite && wCfg == {1'b1, EP_ID}; // R23
      assign clrWr   = doWrite && wCtl == {1'b1, EP_ID} && wrStrb[0] &&
                       wrData[CTL_FIFO_CLR] && endpointEnable[i];
      assign kill    = usbEv.busReset || !endpointEnable[i]; // R1
      assign isCtrl  = endpoint_type[i] == EP_CONTROL;
      assign hostHit = usbEv.hostByte && usbEv.ep == EP_ID;
      assign bankHit = usbEv.bankDone && usbEv.ep == EP_ID;
      assign swHit   = swFifo.access && swFifo.ep == EP_ID;
      assign nb      = {1'b0, bankCode[i]} + 3'h1;
      assign sizeBytes = BANK_UNIT_BYTES << sizeCode[i]; // R7
      assign usage[i]  = 16'(sizeBytes) * {13'h0000, nb};
      assign newCfg  = (cfgWord[i] & ~wrMask) | (wrData & wrMask);
      assign newNeed = (16'(BANK_UNIT_BYTES) <<
                        newCfg[CFG_SIZE_LSB +: 3]) *
                       (16'(newCfg[CFG_BANK_LSB +: 2]) + 16'h0001);
      assign others  = totalBytes - (memory_allocate[i] ? usage[i] : 16'h0000);
      assign fits    =
         newCfg[CFG_BANK_LSB +: 2] != BANK_CODE_RESERVED &&
         newCfg[CFG_BANK_LSB +: 2] <= MAX_BANK &&
         newCfg[CFG_SIZE_LSB +: 3] <= MAX_SIZE &&
         (others + newNeed) <= DPRAM_BYTES; // R11

      always_comb begin
         cfgWord[i] = 32'h0000_0000;
         cfgWord[i][CFG_TYPE_LSB +: 2] = endpoint_type[i];
         cfgWord[i][CFG_AUTO_BANK_SWITCH]        = auto_bank_switch[i];
         cfgWord[i][CFG_DIR]           = dirIn[i];
         cfgWord[i][CFG_SIZE_LSB +: 3] = sizeCode[i];
         cfgWord[i][CFG_BANK_LSB +: 2] = bankCode[i];
         cfgWord[i][CFG_MEMORY_ALLOCATE]         = memory_allocate[i];
         staWord[i] = 32'h0000_0000;
         staWord[i][STA_BYTES_LSB +: 11] = byteCount[i];
         staWord[i][STA_CFG_OK]          = config_ok[i];
         staWord[i][STA_CTRL_DIR]        = control_direction[i];
         staWord[i][STA_RW_OK]           = rwAllowed[i];
         staWord[i][STA_CURR_LSB +: 2]   = currBank[i];
         staWord[i][STA_BUSY_LSB +: 2]   = busyBanks[i];
         staWord[i][STA_DATA_TOGGLE_SEQ_LSB +: 2]  = data_toggle_seq[i];
         ctlWord[i] = 32'h0000_0000;
         ctlWord[i][CTL_BUSY_IE] = busyIrqEn[i];
         ctlWord[i][CTL_STALL]   = stallReq[i];
      end

      // Layout fields except auto_bank_switch survive a disable; a bus reset clears them, sparing size, bank and allocate on endpoint 0
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            endpoint_type[i]   <= EP_CONTROL;
            auto_bank_switch[i]   <= 1'b0;
            dirIn[i]    <= 1'b0;
            sizeCode[i] <= 3'h0;
            bankCode[i] <= 2'h0;
            memory_allocate[i]    <= 1'b0;
         end else if (usbEv.busReset) begin
            endpoint_type[i] <= EP_CONTROL; // R4
            auto_bank_switch[i] <= 1'b0; // R5
            dirIn[i]  <= 1'b0; // R6
            if (i != 0) begin
               sizeCode[i] <= 3'h0; // R7
               bankCode[i] <= 2'h0; // R8
               memory_allocate[i]    <= 1'b0; // R10
            end
         end else if (cfgWr) begin
            endpoint_type[i]   <= uecs_ep_type_e'(newCfg[CFG_TYPE_LSB +: 2]);
            auto_bank_switch[i]   <= newCfg[CFG_AUTO_BANK_SWITCH]; // R5
            dirIn[i]    <= newCfg[CFG_DIR]; // R6
            sizeCode[i] <= newCfg[CFG_SIZE_LSB +: 3];
            bankCode[i] <= newCfg[CFG_BANK_LSB +: 2];
            memory_allocate[i]    <= newCfg[CFG_MEMORY_ALLOCATE]; // R10
         end else if (!endpointEnable[i]) begin
            auto_bank_switch[i] <= 1'b0; // R1
         end
      end

      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            busyIrqEn[i] <= 1'b0;
            stallReq[i]  <= 1'b0;
         end else if (kill) begin
            busyIrqEn[i] <= 1'b0; // R1
            stallReq[i]  <= 1'b0;
         end else if (doWrite && wCtl == {1'b1, EP_ID} && wrStrb[0]) begin
            busyIrqEn[i] <= wrData[CTL_BUSY_IE];
            stallReq[i]  <= wrData[CTL_STALL];
         end
      end

      // Release travels two stages so busy count settles after address
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            clrPipe[i] <= 2'h0;
         end else begin
            clrPipe[i] <= kill ? 2'h0 : {clrPipe[i][0], clrWr}; // R21
         end
      end

      // Software validation and host completion move the count apart
      assign up  = (clrPipe[i][1] && dirIn[i]) || (bankHit && !dirIn[i]);
      assign dn  = (clrPipe[i][1] && !dirIn[i]) || (bankHit && dirIn[i]);
      assign inc = dirIn[i] ? swHit : hostHit;
      assign dec = dirIn[i] ? hostHit : swHit;

      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            busyBanks[i] <= 2'h0;
         end else if (kill) begin
            busyBanks[i] <= 2'h0; // R1
         end else if (up && !dn && {1'b0, busyBanks[i]} < nb) begin
            busyBanks[i] <= busyBanks[i] + 2'h1; // R19
         end else if (dn && !up && busyBanks[i] != 2'h0) begin
            busyBanks[i] <= busyBanks[i] - 2'h1; // R19
         end
      end

      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            byteCount[i] <= 11'h000;
            currBank[i]  <= 2'h0;
         end else if (kill) begin
            byteCount[i] <= 11'h000; // R1
            currBank[i]  <= 2'h0;
         end else if (clrPipe[i][1]) begin
            byteCount[i] <= 11'h000; // R14
            if (!isCtrl) begin
               currBank[i] <= ({1'b0, currBank[i]} + 3'h1 >= nb) ?
                              2'h0 : currBank[i] + 2'h1; // R18
            end
         end else if (inc && !dec && byteCount[i] != BYTE_COUNT_MAX) begin
            byteCount[i] <= byteCount[i] + 11'h001; // R13
         end else if (dec && !inc && byteCount[i] != 11'h000) begin
            byteCount[i] <= byteCount[i] - 11'h001; // R13
         end
      end

      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            config_ok[i]   <= 1'b0;
            control_direction[i] <= 1'b0;
            data_toggle_seq[i]   <= DATA_TOGGLE_SEQ_RESET; // R22
         end else if (kill) begin
            config_ok[i]   <= 1'b0; // R1
            control_direction[i] <= 1'b0;
            data_toggle_seq[i]   <= DATA_TOGGLE_SEQ_RESET; // R22
         end else begin
            if (cfgWr && newCfg[CFG_MEMORY_ALLOCATE]) begin
               config_ok[i] <= fits; // R11
            end
            if (usbEv.setupValid && usbEv.ep == EP_ID) begin
               control_direction[i] <= usbEv.setupDirIn; // R15
            end
            if (bankHit) begin
               data_toggle_seq[i] <= {1'b0, ~data_toggle_seq[i][0]};
            end
         end
      end

      // Registered, so it trails the bank state by one cycle
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            rwAllowed[i] <= 1'b0;
         end else if (kill || isCtrl || stallReq[i] || epError[i]) begin
            rwAllowed[i] <= 1'b0; // R16
         end else if (dirIn[i]) begin
            rwAllowed[i] <= {1'b0, busyBanks[i]} < nb &&
                            byteCount[i] < sizeBytes; // R16
         end else begin
            rwAllowed[i] <= busyBanks[i] != 2'h0 &&
                            byteCount[i] != 11'h000; // R16
         end
      end

      assign irqNext[i] = !kill && busyIrqEn[i] &&
         (dirIn[i] ? busyBanks[i] == 2'h0
                   : {1'b0, busyBanks[i]} == nb); // R20

      property p_disable_clears;
         !endpointEnable[i] && !cfgWr && !usbEv.busReset
         |=> busyBanks[i] == 2'h0 &&
            byteCount[i] == 11'h000 && data_toggle_seq[i] == DATA_TOGGLE_SEQ_RESET &&
            $stable(memory_allocate[i]);
      endproperty
      a_disable_clears: assert property (p_disable_clears) // R1
         else $error("disabled endpoint kept status");

      property p_busy_delay;
         (clrWr && dirIn[i] && clrPipe[i] == 2'h0 && !bankHit &&
          !usbEv.busReset && {1'b0, busyBanks[i]} < nb) ##1
         (endpointEnable[i] && !bankHit && !usbEv.busReset && !cfgWr)[*2]
         |=> busyBanks[i] == $past(busyBanks[i], 3) + 2'h1;
      endproperty
      a_busy_delay: assert property (p_busy_delay) // R21
         else $error("busy count not updated two cycles after release");

      property p_stall_blocks;
         stallReq[i] |=> !rwAllowed[i];
      endproperty
      a_stall_blocks: assert property (p_stall_blocks) // R16
         else $error("read/write allowed during stall");

      property p_irq_in_free;
         !kill && busyIrqEn[i] && dirIn[i] && busyBanks[i] == 2'h0
         |=> endpointIrq[i];
      endproperty
      a_irq_in_free: assert property (p_irq_in_free) // R20
         else $error("missing busy-bank interrupt");

      property p_setup_dir;
         usbEv.setupValid && usbEv.ep == EP_ID && !kill
         |=> control_direction[i] == $past(usbEv.setupDirIn);
      endproperty
      a_setup_dir: assert property (p_setup_dir) // R15
         else $error("control direction not taken from setup");

      property p_reserved_bank;
         cfgWr && newCfg[CFG_MEMORY_ALLOCATE] && !kill &&
         newCfg[CFG_BANK_LSB +: 2] == BANK_CODE_RESERVED |=> !config_ok[i];
      endproperty
      a_reserved_bank: assert property (p_reserved_bank) // R11
         else $error("config ok set for reserved bank count");

      property p_bus_reset_layout;
         usbEv.busReset |=> endpoint_type[i] == EP_CONTROL && !dirIn[i] &&
            (i == 0 ? $stable(sizeCode[i]) : sizeCode[i] == 3'h0);
      endproperty
      a_bus_reset_layout: assert property (p_bus_reset_layout) // R7
         else $error("bus reset left endpoint layout wrong");
   end

   property p_frame_load;
      usbEv.sofValid && !usbEv.busReset
      |=> frameValue == $past(usbEv.sofFrame) &&
          frameCrcError == $past(usbEv.sofCrcError);
   endproperty
   a_frame_load: assert property (p_frame_load) // R3
      else $error("frame number not loaded from SOF");

   property p_frame_clear;
      usbEv.busReset |=> frameValue == 11'h000 && !frameCrcError;
   endproperty
   a_frame_clear: assert property (p_frame_clear) // R2
      else $error("frame number not cleared by bus reset");

   c_sof_crc: cover property (usbEv.sofValid && usbEv.sofCrcError);
   c_cfg_ok: cover property ($rose(config_ok[1]));
   c_irq: cover property ($rose(endpointIrq[1]));
   c_busy_full: cover property (busyBanks[2] == 2'h2);

endmodule

`default_nettype wire
